/* File: inc/cdh_pkg.sv */
// Constants, types and TAP next-state logic for the core debug halt and JTAG port
// What this block does
// - A fetch tagged by the break input halts the core only if it reaches execute.
// - A level halt request halts the core after the current instruction completes.
// - The halt acknowledge output stays high for the whole time in debug state.
// - Instructions shifted in through a scan chain are handed to the core to execute.
// - Each inserted instruction runs at debug speed or at full system speed.
// - Scan chain 2 lets the probe request debug state without the request pin.
// - System reset line is open drain; target may pull it, and its level is monitored.
// - A target retiming its JTAG inputs echoes a retimed test clock back.
// - A target that does not retime may hold the echoed clock low.
// - With mode select held high, stray test clock edges leave the TAP harmless.
// - Test data out changes on falling test clock; inputs sampled on rising edge.
`default_nettype none
package cdh_pkg;
  localparam int IR_W = 4;
  localparam int DR_W = 33;
  localparam int WORD_W = 32;
  localparam logic [IR_W-1:0] IR_SCAN_N = 4'h2;
  localparam logic [IR_W-1:0] IR_RESTART = 4'h4;
  localparam logic [IR_W-1:0] IR_INTEST = 4'hC;
  localparam logic [IR_W-1:0] IR_IDCODE = 4'hE;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] CHAIN_EXEC = 4'h1;
  localparam logic [IR_W-1:0] CHAIN_HALT = 4'h2;
  localparam int SYS_SPEED_BIT = 32;
  localparam int TMS_RESET_EDGES = 5;
  // Arbitrary identification value
  localparam logic [WORD_W-1:0] ID_VALUE = 32'h0000_0001;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UP_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UP_IR
  } cdh_tap_type;

  typedef enum logic [2:0] {
    P_BYPASS, P_SCAN_N, P_EXEC, P_HALT, P_IDCODE
  } cdh_path_type;

  function automatic cdh_tap_type cdh_tap_next(input cdh_tap_type s, input logic tms);
    case (s)
      TLR: cdh_tap_next = tms ? TLR : RTI;
      RTI: cdh_tap_next = tms ? SEL_DR : RTI;
      SEL_DR: cdh_tap_next = tms ? SEL_IR : CAP_DR;
      CAP_DR: cdh_tap_next = tms ? EX1_DR : SH_DR;
      SH_DR: cdh_tap_next = tms ? EX1_DR : SH_DR;
      EX1_DR: cdh_tap_next = tms ? UP_DR : PA_DR;
      PA_DR: cdh_tap_next = tms ? EX2_DR : PA_DR;
      EX2_DR: cdh_tap_next = tms ? UP_DR : SH_DR;
      UP_DR: cdh_tap_next = tms ? SEL_DR : RTI;
      SEL_IR: cdh_tap_next = tms ? TLR : CAP_IR;
      CAP_IR: cdh_tap_next = tms ? EX1_IR : SH_IR;
      SH_IR: cdh_tap_next = tms ? EX1_IR : SH_IR;
      EX1_IR: cdh_tap_next = tms ? UP_IR : PA_IR;
      PA_IR: cdh_tap_next = tms ? EX2_IR : PA_IR;
      EX2_IR: cdh_tap_next = tms ? UP_IR : SH_IR;
      UP_IR: cdh_tap_next = tms ? SEL_DR : RTI;
      default: cdh_tap_next = TLR;
    endcase
  endfunction
endpackage
`default_nettype wire

/* File: hw/cdh_sync.sv */
// Two-flop synchroniser for pins from outside the clock domain
`default_nettype none
module cdh_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta <= INIT;
      q_o <= INIT;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule
`default_nettype wire

/* File: hw/cdh_debug_port.sv */
// Core run-control debug logic with a JTAG port oversampled on the core clock
`default_nettype none
module cdh_debug_port #(
  parameter bit ECHO_ENABLE = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Core pipeline
  input wire logic fetch_valid_i,
  input wire logic fetch_break_tag_i,
  input wire logic pipe_advance_i,
  input wire logic flush_i,
  input wire logic instr_done_i,
  input wire logic [31:0] debug_read_data_i,
  // Debug request and acknowledge pins
  input wire logic halt_request_in_i,
  output logic halted_ack_out_o,
  // Inserted instructions to the core
  output logic [31:0] inserted_instr_o,
  output logic inserted_valid_o,
  output logic inserted_sys_speed_o,
  // JTAG pins
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic test_reset_n_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic echoed_test_clock_o,
  // System reset line, open drain
  input wire logic system_reset_line_n_i,
  output logic system_reset_line_n_o,
  output logic system_reset_line_n_oe_o,
  input wire logic target_reset_req_i,
  output logic sys_reset_seen_o
);
  logic rst_q1;
  logic rst_n;
  logic [5:0] pins_s;
  logic tck_s, tms_s, tdi_s, trst_n_s, req_s, srst_n_s;
  logic tck_d;
  logic tck_rise, tck_fall;
  cdh_pkg::cdh_tap_type tap;
  cdh_pkg::cdh_tap_type next_tap;
  cdh_pkg::cdh_path_type path;
  logic [cdh_pkg::IR_W-1:0] ir;
  logic [cdh_pkg::IR_W-1:0] ir_sh;
  logic [cdh_pkg::IR_W-1:0] chain;
  logic [cdh_pkg::DR_W-1:0] dr;
  logic scan_halt;
  logic halted;
  logic tag_dec;
  logic break_hit;
  logic restart_go;
  logic upd_exec;

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // Idle levels: mode select high, resets released
  cdh_sync #(.W(6), .INIT(6'h2E)) u_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_n),
    .d_i({system_reset_line_n_i, halt_request_in_i, test_reset_n_i, tdi_i, tms_i, tck_i}),
    .q_o(pins_s)
  );
  assign {srst_n_s, req_s, trst_n_s, tdi_s, tms_s, tck_s} = pins_s;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tck_d <= 1'b0;
    end else begin
      tck_d <= tck_s;
    end
  end
  assign tck_rise = tck_s & ~tck_d;
  assign tck_fall = ~tck_s & tck_d;

  // ----------------------------------------------------------------
  // TAP controller
  // ----------------------------------------------------------------
  assign next_tap = cdh_pkg::cdh_tap_next(tap, tms_s);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tap <= cdh_pkg::TLR;
    end else if (!trst_n_s) begin
      tap <= cdh_pkg::TLR;
    end else if (tck_rise) begin
      tap <= next_tap;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ir <= cdh_pkg::IR_IDCODE;
      ir_sh <= '0;
      chain <= '0;
    end else if (!trst_n_s || tap == cdh_pkg::TLR) begin
      ir <= cdh_pkg::IR_IDCODE;
      ir_sh <= '0;
      chain <= '0;
    end else if (tck_rise) begin
      case (tap)
        cdh_pkg::CAP_IR: ir_sh <= cdh_pkg::IR_CAPTURE;
        cdh_pkg::SH_IR: ir_sh <= {tdi_s, ir_sh[cdh_pkg::IR_W-1:1]};
        cdh_pkg::UP_IR: ir <= ir_sh;
        cdh_pkg::UP_DR: begin
          if (path == cdh_pkg::P_SCAN_N) begin
            chain <= dr[cdh_pkg::IR_W-1:0];
          end
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    case (ir)
      cdh_pkg::IR_SCAN_N: path = cdh_pkg::P_SCAN_N;
      cdh_pkg::IR_IDCODE: path = cdh_pkg::P_IDCODE;
      cdh_pkg::IR_INTEST: begin
        if (chain == cdh_pkg::CHAIN_EXEC) begin
          path = cdh_pkg::P_EXEC;
        end else if (chain == cdh_pkg::CHAIN_HALT) begin
          path = cdh_pkg::P_HALT;
        end else begin
          path = cdh_pkg::P_BYPASS;
        end
      end
      default: path = cdh_pkg::P_BYPASS;
    endcase
  end

  // ----------------------------------------------------------------
  // Data register shift path
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dr <= '0;
    end else if (tck_rise && tap == cdh_pkg::CAP_DR) begin
      case (path)
        cdh_pkg::P_EXEC: dr <= {1'b0, debug_read_data_i};
        cdh_pkg::P_HALT: dr <= {32'h0000_0000, halted};
        cdh_pkg::P_IDCODE: dr <= {1'b0, cdh_pkg::ID_VALUE};
        cdh_pkg::P_SCAN_N: dr <= {29'h0000_0000, chain};
        default: dr <= '0;
      endcase
    end else if (tck_rise && tap == cdh_pkg::SH_DR) begin
      case (path)
        cdh_pkg::P_EXEC: dr <= {tdi_s, dr[cdh_pkg::DR_W-1:1]};
        cdh_pkg::P_IDCODE: dr[31:0] <= {tdi_s, dr[31:1]};
        cdh_pkg::P_SCAN_N: dr[3:0] <= {tdi_s, dr[3:1]};
        default: dr[0] <= tdi_s;
      endcase
    end
  end

  // Output moves only on the falling edge, giving the probe half a period
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_o <= (tap == cdh_pkg::SH_DR) || (tap == cdh_pkg::SH_IR);
      if (tap == cdh_pkg::SH_DR) begin
        tdo_o <= dr[0];
      end else if (tap == cdh_pkg::SH_IR) begin
        tdo_o <= ir_sh[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  assign break_hit = pipe_advance_i & tag_dec & ~flush_i;
  assign upd_exec = tck_rise && tap == cdh_pkg::UP_DR && path == cdh_pkg::P_EXEC && halted;
  assign restart_go = tck_rise && ir == cdh_pkg::IR_RESTART && tap != cdh_pkg::RTI &&
                      next_tap == cdh_pkg::RTI;

  // Tag follows the fetched word; a flush drops it before it can execute
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tag_dec <= 1'b0;
    end else if (flush_i) begin
      tag_dec <= 1'b0;
    end else if (pipe_advance_i) begin
      tag_dec <= fetch_valid_i & fetch_break_tag_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      scan_halt <= 1'b0;
    end else if (tck_rise && tap == cdh_pkg::UP_DR && path == cdh_pkg::P_HALT) begin
      scan_halt <= dr[0];
    end else if (restart_go) begin
      scan_halt <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      halted <= 1'b0;
    end else if (restart_go) begin
      halted <= 1'b0;
    end else if (!halted && (break_hit || (instr_done_i && (req_s || scan_halt)))) begin
      halted <= 1'b1;
    end
  end
  assign halted_ack_out_o = halted;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      inserted_instr_o <= '0;
      inserted_sys_speed_o <= 1'b0;
      inserted_valid_o <= 1'b0;
    end else begin
      inserted_valid_o <= upd_exec;
      if (upd_exec) begin
        inserted_instr_o <= dr[31:0];
        inserted_sys_speed_o <= dr[cdh_pkg::SYS_SPEED_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Echoed clock and system reset line
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      echoed_test_clock_o <= 1'b0;
      system_reset_line_n_oe_o <= 1'b0;
      sys_reset_seen_o <= 1'b0;
    end else begin
      echoed_test_clock_o <= ECHO_ENABLE ? tck_s : 1'b0;
      system_reset_line_n_oe_o <= target_reset_req_i;
      sys_reset_seen_o <= ~srst_n_s;
    end
  end
  assign system_reset_line_n_o = 1'b0;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  localparam logic [2:0] TMS_RUN_MAX = 3'(cdh_pkg::TMS_RESET_EDGES);
  logic [2:0] tms_run;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tms_run <= '0;
    end else if (tck_rise) begin
      tms_run <= !tms_s ? 3'h0 : (tms_run == TMS_RUN_MAX ? tms_run : tms_run + 3'h1);
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_shift_exec;
    tck_rise && tap == cdh_pkg::UP_DR && path == cdh_pkg::P_EXEC && halted;
  endsequence

  property p_break_halts;
    !halted && !restart_go && break_hit |=> halted_ack_out_o;
  endproperty
  a_break_halts: assert property (p_break_halts) else $error("tagged instr did not halt");

  property p_flush_clears;
    flush_i |=> !tag_dec;
  endproperty
  a_flush_clears: assert property (p_flush_clears) else $error("flushed tag kept");

  property p_req_halts;
    !halted && !restart_go && req_s && instr_done_i |=> halted_ack_out_o;
  endproperty
  a_req_halts: assert property (p_req_halts) else $error("request did not halt");

  property p_no_midway;
    !halted && !instr_done_i && !break_hit |=> !halted_ack_out_o;
  endproperty
  a_no_midway: assert property (p_no_midway) else $error("halt before completion");

  property p_ack_holds;
    halted && !restart_go |=> halted_ack_out_o;
  endproperty
  a_ack_holds: assert property (p_ack_holds) else $error("ack dropped in debug");

  property p_restart_drops;
    restart_go |=> !halted_ack_out_o;
  endproperty
  a_restart_drops: assert property (p_restart_drops) else $error("ack stayed high");

  property p_insert;
    s_shift_exec |=> inserted_valid_o && inserted_instr_o == $past(dr[31:0]) ##1 !inserted_valid_o;
  endproperty
  a_insert: assert property (p_insert) else $error("inserted instr not issued");

  property p_speed;
    s_shift_exec |=> inserted_sys_speed_o == $past(dr[cdh_pkg::SYS_SPEED_BIT]);
  endproperty
  a_speed: assert property (p_speed) else $error("speed select wrong");

  property p_chain2;
    tck_rise && tap == cdh_pkg::UP_DR && path == cdh_pkg::P_HALT && dr[0] |=> scan_halt;
  endproperty
  a_chain2: assert property (p_chain2) else $error("scan halt not set");

  property p_tms_reset;
    tms_run == TMS_RUN_MAX |-> tap == cdh_pkg::TLR;
  endproperty
  a_tms_reset: assert property (p_tms_reset) else $error("TAP not in reset");

  property p_tdo_fall;
    tdo_o != $past(tdo_o) |-> $past(tck_fall);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off fall");

  property p_echo;
    ##1 echoed_test_clock_o == (ECHO_ENABLE && $past(tck_s));
  endproperty
  a_echo: assert property (p_echo) else $error("echo clock wrong");

  property p_srst;
    target_reset_req_i |=> system_reset_line_n_oe_o && !system_reset_line_n_o;
  endproperty
  a_srst: assert property (p_srst) else $error("reset line not pulled");
endmodule
`default_nettype wire

/* File: bench/cdh_probe_model.sv */
// Behavioural JTAG probe with adaptive clocking, an open-drain system reset pull and a driven test reset
`default_nettype none
module cdh_probe_model (
  // Pacing clock
  input wire logic clk_i,
  // JTAG pins
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_n_o,
  input wire logic echo_i,
  input wire logic tdo_i,
  // System reset line
  output logic srst_pull_o,
  input wire logic srst_i
);
  timeunit 1ns;
  timeprecision 100ps;
  int tmo = 0;
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    trst_n_o = 1'b1;
    srst_pull_o = 1'b0;
  end
  // Off-grid half period keeps TCK unrelated in phase to clk
  task automatic edge_to(input logic v);
    int n;
    n = 0;
    tck_o = v;
    #40.3;
    while (echo_i !== v && n < 60) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 60) tmo++;
  endtask
  task automatic bit_io(input logic ms, input logic di, output logic d);
    tms_o = ms;
    tdi_o = di;
    d = tdo_i;
    edge_to(1'b1);
    edge_to(1'b0);
  endtask
  // From idle to a shift state, n bits LSB first, back to idle
  task automatic scan(input logic ir, input int n, input logic [32:0] din,
                      output logic [32:0] dout);
    logic b;
    dout = '0;
    bit_io(1'b1, 1'b0, b);
    if (ir) bit_io(1'b1, 1'b0, b);
    bit_io(1'b0, 1'b0, b);
    bit_io(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      bit_io(i == n - 1, din[i], b);
      dout[i] = b;
    end
    bit_io(1'b1, 1'b0, b);
    bit_io(1'b0, 1'b0, b);
  endtask
  task automatic tap_reset();
    logic b;
    repeat (6) bit_io(1'b1, 1'b1, b);
    bit_io(1'b0, 1'b1, b);
  endtask
  task automatic trst_pulse();
    trst_n_o = 1'b0;
    #100;
    trst_n_o = 1'b1;
  endtask
  task automatic pull(input logic v);
    srst_pull_o = v;
  endtask
endmodule
`default_nettype wire

/* File: bench/test_core_debug_halt_and_jtag_port.sv */
// Self-checking bench for the debug halt and JTAG port
`default_nettype none
module test_core_debug_halt_and_jtag_port;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, rst_b_i, fetch_valid_i, fetch_break_tag_i, pipe_advance_i, flush_i;
  logic instr_done_i, halt_request_in_i, halted_ack_out_o, inserted_valid_o;
  logic inserted_sys_speed_o, tck_i, tms_i, tdi_i, test_reset_n_i, tdo_o, tdo_oe_o;
  logic echoed_test_clock_o, system_reset_line_n_o, system_reset_line_n_oe_o;
  logic target_reset_req_i, sys_reset_seen_o, srst_pull;
  logic [31:0] debug_read_data_i, inserted_instr_o, instr, last_instr;
  logic [32:0] got;
  logic last_speed;
  int miscompares = 0, checks_done = 0, cyc = 0, pulses = 0, p0;
  wire logic system_reset_line_n_i;
  wire logic tdo_line;
  // Both lines have pull-ups when nobody drives them
  assign system_reset_line_n_i = system_reset_line_n_oe_o ? system_reset_line_n_o :
                                 (srst_pull ? 1'b0 : 1'b1);
  assign tdo_line = tdo_oe_o ? tdo_o : 1'b1;
  cdh_debug_port cdh_debug_port_i (.clk_i, .rst_b_i, .fetch_valid_i, .fetch_break_tag_i,
    .pipe_advance_i, .flush_i, .instr_done_i, .debug_read_data_i, .halt_request_in_i,
    .halted_ack_out_o, .inserted_instr_o, .inserted_valid_o, .inserted_sys_speed_o,
    .tck_i, .tms_i, .tdi_i, .test_reset_n_i, .tdo_o, .tdo_oe_o, .echoed_test_clock_o,
    .system_reset_line_n_i, .system_reset_line_n_o, .system_reset_line_n_oe_o,
    .target_reset_req_i, .sys_reset_seen_o);
  cdh_probe_model cdh_probe_model_i (.clk_i, .tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i),
    .trst_n_o(test_reset_n_i), .echo_i(echoed_test_clock_o), .tdo_i(tdo_line),
    .srst_pull_o(srst_pull), .srst_i(system_reset_line_n_i));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (inserted_valid_o === 1'b1) begin
      pulses++;
      last_instr = inserted_instr_o;
      last_speed = inserted_sys_speed_o;
    end
    if (cyc == 60000) begin
      miscompares++;
      results();
    end
  end
  task automatic results();
    if (miscompares == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [32:0] g, input logic [32:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic chk1(input logic g, input logic e, input string m);
    chk({32'h0, g}, {32'h0, e}, m);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic pipe(input logic adv, input logic tag, input logic fl, input logic dn);
    wait_n(1);
    pipe_advance_i = adv;
    fetch_valid_i = adv;
    fetch_break_tag_i = tag;
    flush_i = fl;
    instr_done_i = dn;
  endtask
  task automatic ir(input logic [3:0] code);
    cdh_probe_model_i.scan(1'b1, 4, {29'h0, code}, got);
    chk(got[3:0], cdh_pkg::IR_CAPTURE, "ir capture");
  endtask
  task automatic restart();
    // Code acts on the next entry to idle; left loaded it would restart every scan
    ir(cdh_pkg::IR_RESTART);
    ir(cdh_pkg::IR_BYPASS);
    chk1(halted_ack_out_o, 1'b0, "ack after restart");
  endtask
  task automatic chain(input logic [3:0] c);
    ir(cdh_pkg::IR_SCAN_N);
    cdh_probe_model_i.scan(1'b0, 4, {29'h0, c}, got);
    ir(cdh_pkg::IR_INTEST);
  endtask
  initial begin
    {rst_b_i, fetch_valid_i, fetch_break_tag_i, pipe_advance_i, flush_i} = '0;
    {instr_done_i, halt_request_in_i, target_reset_req_i} = '0;
    debug_read_data_i = 32'h0;
    void'($urandom(32'hC8CA));
    wait_n(2);
    rst_b_i = 1'b1;
    wait_n(6);
    chk1(halted_ack_out_o, 1'b0, "ack after reset");
    cdh_probe_model_i.tap_reset();
    ir(cdh_pkg::IR_BYPASS);
    cdh_probe_model_i.tap_reset();
    cdh_probe_model_i.scan(1'b0, 32, 33'h0, got);
    chk(got[31:0], cdh_pkg::ID_VALUE, "idcode after tms high");
    // Flushed tag must never halt
    pipe(1'b1, 1'b1, 1'b0, 1'b0);
    pipe(1'b0, 1'b0, 1'b1, 1'b0);
    pipe(1'b1, 1'b0, 1'b0, 1'b0);
    pipe(1'b0, 1'b0, 1'b0, 1'b0);
    wait_n(3);
    chk1(halted_ack_out_o, 1'b0, "flushed tag halted");
    pipe(1'b1, 1'b1, 1'b0, 1'b0);
    pipe(1'b1, 1'b0, 1'b0, 1'b0);
    chk1(halted_ack_out_o, 1'b0, "halt before execute");
    pipe(1'b0, 1'b0, 1'b0, 1'b0);
    chk1(halted_ack_out_o, 1'b1, "break halt");
    restart();
    halt_request_in_i = 1'b1;
    wait_n(6);
    chk1(halted_ack_out_o, 1'b0, "halt before done");
    pipe(1'b0, 1'b0, 1'b0, 1'b1);
    pipe(1'b0, 1'b0, 1'b0, 1'b0);
    chk1(halted_ack_out_o, 1'b1, "request halt");
    for (int i = 0; i < 20; i++) begin
      pipe(1'b0, 1'b0, 1'b0, i[0]);
      chk1(halted_ack_out_o, 1'b1, "ack dropped in debug");
    end
    chain(cdh_pkg::CHAIN_EXEC);
    for (int k = 0; k < 2; k++) begin
      instr = $urandom;
      debug_read_data_i = $urandom;
      p0 = pulses;
      cdh_probe_model_i.scan(1'b0, 33, {k[0], instr}, got);
      chk(got[31:0], debug_read_data_i, "captured core data");
      chk(pulses - p0, 1, "insert pulse count");
      chk(last_instr, instr, "inserted word");
      chk1(last_speed, k[0], "speed flag");
    end
    halt_request_in_i = 1'b0;
    wait_n(4);
    restart();
    ir(cdh_pkg::IR_INTEST);
    p0 = pulses;
    cdh_probe_model_i.scan(1'b0, 33, 33'h1_0000_0000, got);
    chk(pulses - p0, 0, "insert while running");
    chain(cdh_pkg::CHAIN_HALT);
    cdh_probe_model_i.scan(1'b0, 1, 33'h1, got);
    chk1(got[0], 1'b0, "chain2 capture running");
    pipe(1'b0, 1'b0, 1'b0, 1'b1);
    pipe(1'b0, 1'b0, 1'b0, 1'b0);
    chk1(halted_ack_out_o, 1'b1, "scan halt");
    cdh_probe_model_i.scan(1'b0, 1, 33'h0, got);
    chk1(got[0], 1'b1, "chain2 capture halted");
    restart();
    pipe(1'b0, 1'b0, 1'b0, 1'b1);
    pipe(1'b0, 1'b0, 1'b0, 1'b0);
    chk1(halted_ack_out_o, 1'b0, "scan halt not cleared");
    target_reset_req_i = 1'b1;
    wait_n(2);
    chk1(system_reset_line_n_i, 1'b0, "target pull");
    wait_n(4);
    chk1(sys_reset_seen_o, 1'b1, "own reset seen");
    target_reset_req_i = 1'b0;
    wait_n(6);
    chk1(sys_reset_seen_o, 1'b0, "reset seen stuck");
    cdh_probe_model_i.pull(1'b1);
    wait_n(6);
    chk1(sys_reset_seen_o, 1'b1, "probe reset seen");
    chk1(system_reset_line_n_oe_o, 1'b0, "oe without request");
    cdh_probe_model_i.pull(1'b0);
    ir(cdh_pkg::IR_BYPASS);
    cdh_probe_model_i.trst_pulse();
    cdh_probe_model_i.bit_io(1'b0, 1'b0, got[0]);
    cdh_probe_model_i.scan(1'b0, 32, 33'h0, got);
    chk(got[31:0], cdh_pkg::ID_VALUE, "idcode after test reset");
    chk(cdh_probe_model_i.tmo, 0, "echo timeout");
    results();
  end
endmodule
`default_nettype wire
